/* File: djl_device.sv */
// Down-converter and serial link control bank, device end
// Summary of operation
// RULE_01 - Gain boost bit picks 0 dB or 6.02 dB
// RULE_02 - Decimation code selects factor 4 to 32
// RULE_03 - Change decimation only while link disabled
// RULE_04 - Bit 7 enables the data scrambler
// RULE_05 - Frames per multiframe minus one, reset 3
// RULE_06 - Frames per multiframe must suit decimation, rate; the controller only refuses fewer than 2
// RULE_07 - Double rate bit doubles serial bit rate
// RULE_08 - Link disabled: reset, power down, clocks gated
// RULE_09 - Disable link before changing primary control
// RULE_10 - Five-fourths PLL scales serial rate by 1.25
// RULE_11 - Sync select picks single-ended or differential pin
// RULE_12 - Test codes 0 to 7 pick patterns
// RULE_13 - Test codes 8 to 11 pick further patterns
// RULE_14 - Secondary control changed only while link disabled
// RULE_15 - Status bit reports selected sync level
// RULE_16 - Never program reserved decimation or test codes
`timescale 1ns/1ps
module djl_device (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    djl_if.dev bus,
    // Sync pins from the receiver, low active
    input wire logic sync_single_ended_pin_n,
    input wire logic sync_differential_pin_n,
    // Down-converter settings
    output logic final_filter_gain_boost,
    output logic [5:0] decimation_factor,
    output logic decimation_valid,
    // Link settings
    output logic scrambler_enable,
    output logic [5:0] frames_per_multiframe,
    output logic [3:0] bit_rate_quarters,
    output logic link_reset,
    output logic serializer_power_down,
    output logic link_clock_enable,
    output logic sync_n,
    // Test pattern
    output djl_pkg::djl_test_t link_test_pattern_select,
    output logic [7:0] test_byte,
    output logic test_byte_is_k
);
    import djl_pkg::*;

    logic [7:0] ddc_ff;
    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl2_ff;
    logic ack_ff;
    logic [7:0] rdata_ff;
    logic sync_n_ff;
    logic [22:0] lfsr_ff;
    logic [22:0] nxt_lfsr;
    logic [7:0] ramp_ff;
    logic [7:0] test_byte_ff;
    logic [7:0] nxt_test_byte;
    logic test_k_ff;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
        hit = (a == off);
    endfunction

    // Factor 0 marks a reserved code
    function automatic logic [5:0] dec_factor(input logic [3:0] code);
        case (code)
            4'h0: dec_factor = 6'd4;
            4'h2: dec_factor = 6'd4;
            4'h3: dec_factor = 6'd8;
            4'h4: dec_factor = 6'd10;
            4'h5: dec_factor = 6'd16;
            4'h6: dec_factor = 6'd20;
            4'h7: dec_factor = 6'd32;
            default: dec_factor = 6'd0;
        endcase
    endfunction

    // Register access: one access per request, answered next cycle
    wire acc = bus.req && !ack_ff;
    wire wr = acc && bus.we;
    wire wr_ddc = wr && hit(bus.addr, OFF_DDC_CTRL);
    wire wr_c1 = wr && hit(bus.addr, OFF_LINK_CTRL1);
    wire wr_c2 = wr && hit(bus.addr, OFF_LINK_CTRL2);

    wire link_en = ctrl1_ff[L1_EN_BIT];
    wire [3:0] dec_code = ddc_ff[DDC_DEC_LSB +: DDC_DEC_W];
    wire [4:0] k_m1 = ctrl1_ff[L1_K_LSB +: L1_K_W];
    wire [3:0] test_code = ctrl2_ff[L2_TEST_LSB +: L2_TEST_W];
    wire ddr = ctrl1_ff[L1_DDR_BIT];
    wire p54 = ctrl2_ff[L2_P54_BIT];

    // Sync source routing, see RULE_11
    wire sync_sel = ctrl2_ff[L2_SYNC_BIT] ? sync_differential_pin_n
                                          : sync_single_ended_pin_n;

    // Status byte, see RULE_15
    wire [7:0] status_byte = 8'(sync_n_ff) << ST_SYNC_BIT;

    wire [7:0] rd_mux =
        hit(bus.addr, OFF_DDC_CTRL) ? ddc_ff :
        hit(bus.addr, OFF_LINK_CTRL1) ? ctrl1_ff :
        hit(bus.addr, OFF_LINK_CTRL2) ? ctrl2_ff :
        hit(bus.addr, OFF_LINK_STATUS) ? status_byte : 8'h00;

    // Register file; unmapped writes are dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            ddc_ff <= RST_DDC_CTRL;
            ctrl1_ff <= RST_LINK_CTRL1;
            ctrl2_ff <= RST_LINK_CTRL2;
        end else begin
            if (wr_ddc) begin
                ddc_ff <= bus.wdata;
            end
            if (wr_c1) begin
                ctrl1_ff <= bus.wdata;
            end
            if (wr_c2) begin
                ctrl2_ff <= bus.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
            rdata_ff <= 8'h00;
            sync_n_ff <= 1'b1;
        end else begin
            ack_ff <= acc;
            sync_n_ff <= sync_sel;
            if (acc && !bus.we) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    assign bus.ack = ack_ff;
    assign bus.rdata = rdata_ff;
    assign sync_n = sync_n_ff;

    // Settings derived straight from the register flops
    assign final_filter_gain_boost = ddc_ff[DDC_GAIN_BIT]; // see RULE_01
    assign decimation_factor = dec_factor(dec_code); // see RULE_02
    assign decimation_valid = (decimation_factor != 6'd0); // see RULE_02
    assign scrambler_enable = ctrl1_ff[L1_SCR_BIT]; // see RULE_04
    assign frames_per_multiframe = {1'b0, k_m1} + 6'd1; // see RULE_05
    // see RULE_07 and RULE_10
    assign bit_rate_quarters = p54 ? (ddr ? RATE_X25 : RATE_X125)
                                   : (ddr ? RATE_X2 : RATE_X1);
    // Disabled link is held in reset, powered down and unclocked
    assign link_reset = !link_en; // see RULE_08
    assign serializer_power_down = !link_en; // see RULE_08
    assign link_clock_enable = link_en; // see RULE_08

    // see RULE_12 and RULE_13
    assign link_test_pattern_select = (test_code >= TEST_FIRST_RSVD) ?
        DJL_TEST_RSVD : djl_test_t'(test_code);

    // Pattern generator; a disabled link has no clock so it restarts
    wire prbs_mode = (link_test_pattern_select == DJL_TEST_PRBS7) ||
                     (link_test_pattern_select == DJL_TEST_PRBS15) ||
                     (link_test_pattern_select == DJL_TEST_PRBS23);
    wire fb7 = lfsr_ff[6] ^ lfsr_ff[5];
    wire fb15 = lfsr_ff[14] ^ lfsr_ff[13];
    wire fb23 = lfsr_ff[22] ^ lfsr_ff[17];

    always_comb begin
        nxt_lfsr = lfsr_ff;
        case (link_test_pattern_select)
            DJL_TEST_PRBS7: nxt_lfsr = {16'h0000, lfsr_ff[5:0], fb7};
            DJL_TEST_PRBS15: nxt_lfsr = {8'h00, lfsr_ff[13:0], fb15};
            DJL_TEST_PRBS23: nxt_lfsr = {lfsr_ff[21:0], fb23};
            default: nxt_lfsr = LFSR_SEED;
        endcase
    end

    // see RULE_12 and RULE_13
    always_comb begin
        nxt_test_byte = BYTE_LOW;
        case (link_test_pattern_select)
            DJL_TEST_PRBS7: nxt_test_byte = lfsr_ff[7:0];
            DJL_TEST_PRBS15: nxt_test_byte = lfsr_ff[7:0];
            DJL_TEST_PRBS23: nxt_test_byte = lfsr_ff[7:0];
            DJL_TEST_RAMP: nxt_test_byte = ramp_ff;
            DJL_TEST_D21_5: nxt_test_byte = BYTE_D21_5;
            DJL_TEST_K28_5: nxt_test_byte = BYTE_K28_5;
            DJL_TEST_HIGH: nxt_test_byte = BYTE_HIGH;
            default: nxt_test_byte = BYTE_LOW;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || !link_en) begin
            lfsr_ff <= LFSR_SEED;
            ramp_ff <= 8'h00;
            test_byte_ff <= BYTE_LOW;
            test_k_ff <= 1'b0;
        end else begin
            lfsr_ff <= prbs_mode ? nxt_lfsr : LFSR_SEED;
            ramp_ff <= ramp_ff + 8'h01;
            test_byte_ff <= nxt_test_byte;
            test_k_ff <= (link_test_pattern_select == DJL_TEST_K28_5);
        end
    end

    assign test_byte = test_byte_ff;
    assign test_byte_is_k = test_k_ff;
endmodule

/* File: djl_pkg.sv */
// Shared constants and types for the down-converter and link control bank
package djl_pkg;
    // Device register port geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    // Device register offsets
    localparam logic [9:0] OFF_DDC_CTRL = 10'h200;
    localparam logic [9:0] OFF_LINK_CTRL1 = 10'h201;
    localparam logic [9:0] OFF_LINK_CTRL2 = 10'h202;
    localparam logic [9:0] OFF_LINK_STATUS = 10'h205;

    // Reset values
    localparam logic [7:0] RST_DDC_CTRL = 8'h10;
    localparam logic [7:0] RST_LINK_CTRL1 = 8'h0F;
    localparam logic [7:0] RST_LINK_CTRL2 = 8'h00;

    // Down-converter control fields
    localparam int DDC_GAIN_BIT = 4;
    localparam int DDC_DEC_LSB = 0;
    localparam int DDC_DEC_W = 4;

    // Primary link control fields
    localparam int L1_SCR_BIT = 7;
    localparam int L1_K_LSB = 2;
    localparam int L1_K_W = 5;
    localparam int L1_DDR_BIT = 1;
    localparam int L1_EN_BIT = 0;

    // Secondary link control fields
    localparam int L2_P54_BIT = 7;
    localparam int L2_SYNC_BIT = 6;
    localparam logic [7:0] L2_RSVD_MASK = 8'h30;
    localparam int L2_TEST_LSB = 0;
    localparam int L2_TEST_W = 4;

    // Status register field
    localparam int ST_SYNC_BIT = 5;

    // Decimation codes
    localparam logic [3:0] DEC_FIRST_RSVD = 4'h8;
    localparam logic [3:0] DEC_HOLE = 4'h1;
    // Test codes at and above this are reserved
    localparam logic [3:0] TEST_FIRST_RSVD = 4'hC;

    // Serial bit rate, in quarters of the sample rate
    localparam logic [3:0] RATE_X1 = 4'h4;
    localparam logic [3:0] RATE_X2 = 4'h8;
    localparam logic [3:0] RATE_X125 = 4'h5;
    localparam logic [3:0] RATE_X25 = 4'hA;

    // Fixed test bytes and the PRBS seed
    localparam logic [7:0] BYTE_D21_5 = 8'hB5;
    localparam logic [7:0] BYTE_K28_5 = 8'hBC;
    localparam logic [7:0] BYTE_LOW = 8'h00;
    localparam logic [7:0] BYTE_HIGH = 8'hFF;
    localparam logic [22:0] LFSR_SEED = 23'h7FFFFF;

    // Controller Wishbone register offsets (byte addresses)
    localparam logic [3:0] WB_OFF_CMD = 4'h0;
    localparam logic [3:0] WB_OFF_STATUS = 4'h4;
    // Command register fields
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_WE_BIT = 24;
    localparam int CMD_START_BIT = 31;
    // Status register fields
    localparam int STS_BUSY_BIT = 8;
    localparam int STS_REFUSED_BIT = 9;
    localparam int STS_LINK_EN_BIT = 10;
    // Smallest legal frames-per-multiframe minus one
    localparam logic [4:0] K_M1_MIN = 5'h01;

    typedef enum logic [3:0] {
        DJL_TEST_NORMAL,
        DJL_TEST_PRBS7,
        DJL_TEST_PRBS15,
        DJL_TEST_PRBS23,
        DJL_TEST_RAMP,
        DJL_TEST_TRANSPORT,
        DJL_TEST_D21_5,
        DJL_TEST_K28_5,
        DJL_TEST_ILA,
        DJL_TEST_RPAT,
        DJL_TEST_LOW,
        DJL_TEST_HIGH,
        DJL_TEST_RSVD
    } djl_test_t;

    typedef enum {
        DJL_H_IDLE,
        DJL_H_WAIT
    } djl_host_state_t;
endpackage

/* File: djl_if.sv */
// Register port between the link controller and the control bank
`timescale 1ns/1ps
interface djl_if;
    import djl_pkg::*;
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic ack;

    modport dev (
        input req,
        input we,
        input addr,
        input wdata,
        output rdata,
        output ack
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input rdata,
        input ack
    );
endinterface

/* File: djl_host.sv */
// Link controller: Wishbone slave that drives the control bank port
`timescale 1ns/1ps
module djl_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Register port toward the bank
    djl_if.host bus
);
    import djl_pkg::*;

    djl_host_state_t state_ff;
    logic wb_ack_ff;
    logic [31:0] wb_dat_ff;
    logic [31:0] cmd_ff;
    logic [31:0] nxt_cmd;
    logic refused_ff;
    logic [7:0] rdata_ff;
    logic req_ff;
    logic we_ff;
    logic [9:0] addr_ff;
    logic [7:0] wdata_ff;
    logic [7:0] sh_ddc_ff;
    logic [7:0] sh_c1_ff;

    wire wb_acc = wb_cyc_i && wb_stb_i && !wb_ack_ff;
    wire wb_wr = wb_acc && wb_we_i;
    wire wr_cmd = wb_wr && (wb_adr_i == WB_OFF_CMD);
    wire wr_sts = wb_wr && (wb_adr_i == WB_OFF_STATUS);
    wire busy = (state_ff == DJL_H_WAIT);

    always_comb begin
        nxt_cmd = cmd_ff;
        for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
                nxt_cmd[i*8 +: 8] = wb_dat_i[i*8 +: 8];
            end
        end
    end

    wire start = wr_cmd && wb_sel_i[3] && wb_dat_i[CMD_START_BIT];
    wire [9:0] c_addr = nxt_cmd[CMD_ADDR_LSB +: ADDR_W];
    wire c_we = nxt_cmd[CMD_WE_BIT];
    wire [7:0] c_data = nxt_cmd[CMD_DATA_LSB +: DATA_W];
    wire sh_en = sh_c1_ff[L1_EN_BIT];

    // Reserved bits of the secondary register always go out as zero
    wire is_c2 = (c_addr == OFF_LINK_CTRL2);
    wire [7:0] out_data = is_c2 ? (c_data & ~L2_RSVD_MASK) : c_data; // see RULE_14

    wire [3:0] c_dec = c_data[DDC_DEC_LSB +: DDC_DEC_W];
    wire dec_rsvd = (c_dec == DEC_HOLE) || (c_dec >= DEC_FIRST_RSVD);
    wire dec_chg = (c_dec != sh_ddc_ff[DDC_DEC_LSB +: DDC_DEC_W]);
    wire c1_chg = (c_data[7:1] != sh_c1_ff[7:1]);
    wire k_bad = (c_data[L1_K_LSB +: L1_K_W] < K_M1_MIN);
    wire test_rsvd = (c_data[L2_TEST_LSB +: L2_TEST_W] >= TEST_FIRST_RSVD);

    // Writes that would break the bank's programming order are refused
    wire bad_ddc = (c_addr == OFF_DDC_CTRL) &&
                   ((sh_en && dec_chg) || dec_rsvd); // see RULE_03, RULE_16
    wire bad_c1 = (c_addr == OFF_LINK_CTRL1) &&
                  (c1_chg && (sh_en || c_data[L1_EN_BIT]) || k_bad); // see RULE_09, RULE_06
    wire bad_c2 = is_c2 && (sh_en || test_rsvd); // see RULE_14, RULE_16
    wire refuse = c_we && (bad_ddc || bad_c1 || bad_c2);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= DJL_H_IDLE;
            req_ff <= 1'b0;
            we_ff <= 1'b0;
            addr_ff <= 10'h000;
            wdata_ff <= 8'h00;
            rdata_ff <= 8'h00;
            sh_ddc_ff <= RST_DDC_CTRL;
            sh_c1_ff <= RST_LINK_CTRL1;
        end else begin
            case (state_ff)
                DJL_H_IDLE: begin
                    if (start && !refuse) begin
                        req_ff <= 1'b1;
                        we_ff <= c_we;
                        addr_ff <= c_addr;
                        wdata_ff <= out_data;
                        state_ff <= DJL_H_WAIT;
                    end
                end
                DJL_H_WAIT: begin
                    if (bus.ack) begin
                        req_ff <= 1'b0;
                        state_ff <= DJL_H_IDLE;
                        if (!we_ff) begin
                            rdata_ff <= bus.rdata;
                        end
                        if (we_ff && addr_ff == OFF_DDC_CTRL) begin
                            sh_ddc_ff <= wdata_ff;
                        end
                        if (we_ff && addr_ff == OFF_LINK_CTRL1) begin
                            sh_c1_ff <= wdata_ff;
                        end
                    end
                end
                default: state_ff <= DJL_H_IDLE;
            endcase
        end
    end

    // Refused flag: a new refusal wins over a clear in the same cycle
    wire set_ref = start && !busy && refuse;
    wire clr_ref = wr_sts && wb_sel_i[1] && wb_dat_i[STS_REFUSED_BIT];

    wire [31:0] sts_word = {21'h000000, sh_en, refused_ff, busy, rdata_ff};
    wire [31:0] rd_mux = (wb_adr_i == WB_OFF_CMD) ? cmd_ff :
                         (wb_adr_i == WB_OFF_STATUS) ? sts_word : 32'h00000000;

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_ff <= 1'b0;
            wb_dat_ff <= 32'h00000000;
            cmd_ff <= 32'h00000000;
            refused_ff <= 1'b0;
        end else begin
            wb_ack_ff <= wb_acc;
            if (wb_acc && !wb_we_i) begin
                wb_dat_ff <= rd_mux;
            end
            if (wr_cmd) begin
                cmd_ff <= {1'b0, nxt_cmd[30:0]};
            end
            refused_ff <= set_ref | (refused_ff & ~clr_ref);
        end
    end

    assign wb_ack_o = wb_ack_ff;
    assign wb_dat_o = wb_dat_ff;
    assign bus.req = req_ff;
    assign bus.we = we_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = wdata_ff;
endmodule

/* File: djl_sva.sv */
// Assertions on the register port between controller and bank
`timescale 1ns/1ps
module djl_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic req,
    input wire logic we,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    import djl_pkg::*;
    logic [7:0] ddc_ff;
    logic [7:0] ctl1_ff;
    wire taken = req && !ack;
    wire wr = taken && we;
    wire link_on = ctl1_ff[L1_EN_BIT];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Shadows follow only writes that really cross the port
    always_ff @(posedge clk) begin
        if (rst) begin
            ddc_ff <= RST_DDC_CTRL;
            ctl1_ff <= RST_LINK_CTRL1;
        end else if (wr && addr == OFF_DDC_CTRL) begin
            ddc_ff <= wdata;
        end else if (wr && addr == OFF_LINK_CTRL1) begin
            ctl1_ff <= wdata;
        end
    end
    chk_ack_answers: assert property (taken |=> ack)
        else $error("no ack after request");
    chk_ack_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    chk_ack_caused: assert property (ack |-> $past(taken))
        else $error("ack without request");
    chk_req_steady: assert property (taken |=> req && $stable(addr)
        && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    chk_req_release: assert property (ack |=> !req)
        else $error("request held after ack");
    chk_status_bits: assert property (taken && !we
        && addr == OFF_LINK_STATUS |=> (rdata & 8'hDF) == 8'h00)
        else $error("status read has stray bits");
    chk_dec_locked: assert property (wr && addr == OFF_DDC_CTRL && link_on
        |-> wdata[3:0] == ddc_ff[3:0])
        else $error("decimation changed while link on");
    chk_dec_legal: assert property (wr && addr == OFF_DDC_CTRL |->
        wdata[3:0] != DEC_HOLE && wdata[3:0] < DEC_FIRST_RSVD)
        else $error("reserved decimation code sent");
    chk_ctl1_order: assert property (wr && addr == OFF_LINK_CTRL1
        && wdata[7:1] != ctl1_ff[7:1] |-> !link_on && !wdata[0])
        else $error("link control changed while enabled");
    chk_k_legal: assert property (wr && addr == OFF_LINK_CTRL1
        |-> wdata[6:2] >= K_M1_MIN)
        else $error("illegal multiframe length sent");
    chk_ctl2_locked: assert property (wr && addr == OFF_LINK_CTRL2
        |-> !link_on && wdata[5:4] == 2'b00)
        else $error("second control written badly");
    chk_test_legal: assert property (wr && addr == OFF_LINK_CTRL2
        |-> wdata[3:0] < TEST_FIRST_RSVD)
        else $error("reserved test code sent");
    cover property (wr && addr == OFF_LINK_CTRL2);
    cover property (taken && !we && addr == OFF_LINK_STATUS);
    cover property (wr && addr == OFF_LINK_CTRL1 && wdata[0]);
endmodule

/* File: ddc_jesd_link_control_regs_tb.sv */
// Self-checking bench for the down-converter and link control bank
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module ddc_jesd_link_control_regs_tb;
    import djl_pkg::*;
    logic clk;
    logic rst;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [3:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic sync_single_ended_pin_n;
    logic sync_differential_pin_n;
    logic final_filter_gain_boost;
    logic [5:0] decimation_factor;
    logic decimation_valid;
    logic scrambler_enable;
    logic [5:0] frames_per_multiframe;
    logic [3:0] bit_rate_quarters;
    logic link_reset;
    logic serializer_power_down;
    logic link_clock_enable;
    logic sync_n;
    djl_test_t link_test_pattern_select;
    logic [7:0] test_byte;
    logic test_byte_is_k;
    logic [31:0] s;
    int error_cnt = 0;
    int total_checks = 0;
    djl_if dif();
    djl_host i_djl_host (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus(dif));
    djl_device i_djl_device (.clk, .rst, .bus(dif), .sync_single_ended_pin_n,
        .sync_differential_pin_n, .final_filter_gain_boost,
        .decimation_factor, .decimation_valid, .scrambler_enable,
        .frames_per_multiframe, .bit_rate_quarters, .link_reset,
        .serializer_power_down, .link_clock_enable, .sync_n,
        .link_test_pattern_select, .test_byte, .test_byte_is_k);
    djl_sva i_djl_sva (.clk, .rst, .req(dif.req), .we(dif.we),
        .addr(dif.addr), .wdata(dif.wdata), .rdata(dif.rdata),
        .ack(dif.ack));

    task automatic check(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One classic cycle; a dead slave is caught by the watchdog
    task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        `CHK("wb latency", 2, n);
        s = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic dev(logic w, logic [9:0] a, logic [7:0] d);
        int n;
        wb(1'b1, WB_OFF_CMD, {1'b1, 6'h00, w, 6'h00, a, d});
        n = 0;
        do begin
            wb(1'b0, WB_OFF_STATUS, 32'h0);
            n++;
        end while (s[STS_BUSY_BIT] && n < 10);
    endtask

    task automatic bad(logic [9:0] a, logic [7:0] d);
        dev(1'b1, a, d);
        `CHK("refused", 1, s[STS_REFUSED_BIT]);
        wb(1'b1, WB_OFF_STATUS, 32'h0000_0200);
        wb(1'b0, WB_OFF_STATUS, 32'h0);
        `CHK("cleared", 0, s[STS_REFUSED_BIT]);
    endtask

    task automatic t_reset();
        logic [7:0] rv [3] = '{8'h10, 8'h0F, 8'h00};
        `CHK("gain", 1, final_filter_gain_boost);
        `CHK("dec", 4, decimation_factor);
        `CHK("scr", 0, scrambler_enable);
        `CHK("fpm", 4, frames_per_multiframe);
        `CHK("rate", 8, bit_rate_quarters);
        `CHK("lrst", 0, link_reset);
        `CHK("pattern", 0, link_test_pattern_select);
        `CHK("sync", 1, sync_n);
        for (int i = 0; i < 3; i++) begin
            dev(1'b0, OFF_DDC_CTRL + 10'(i), 8'h00);
            `CHK("reset value", rv[i], s[7:0]);
        end
    endtask

    task automatic t_locked();
        bad(OFF_DDC_CTRL, 8'h13);
        `CHK("dec kept", 4, decimation_factor);
        bad(OFF_LINK_CTRL1, 8'h8F);
        bad(OFF_LINK_CTRL2, 8'h00);
        `CHK("scr kept", 0, scrambler_enable);
        dev(1'b1, OFF_LINK_CTRL1, 8'h0E);
        `CHK("lrst", 1, link_reset);
        `CHK("pd", 1, serializer_power_down);
        `CHK("clken", 0, link_clock_enable);
    endtask

    task automatic t_decim();
        logic [3:0] code [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
        int fac [7] = '{4, 4, 8, 10, 16, 20, 32};
        for (int i = 0; i < 7; i++) begin
            dev(1'b1, OFF_DDC_CTRL, {4'h0, code[i]});
            `CHK("dec", fac[i], decimation_factor);
            `CHK("dec ok", 1, decimation_valid);
            `CHK("gain", 0, final_filter_gain_boost);
        end
        bad(OFF_DDC_CTRL, 8'h01);
        bad(OFF_DDC_CTRL, 8'h08);
        `CHK("dec kept", 32, decimation_factor);
        dev(1'b1, OFF_DDC_CTRL, 8'h10);
        `CHK("gain", 1, final_filter_gain_boost);
    endtask

    task automatic t_link();
        dev(1'b1, OFF_LINK_CTRL1, 8'h9C);
        `CHK("scr", 1, scrambler_enable);
        `CHK("fpm", 8, frames_per_multiframe);
        `CHK("rate", 4, bit_rate_quarters);
        bad(OFF_LINK_CTRL1, 8'h80);
        dev(1'b1, OFF_LINK_CTRL2, 8'h80);
        `CHK("rate", 5, bit_rate_quarters);
        dev(1'b1, OFF_LINK_CTRL1, 8'hFE);
        `CHK("fpm", 32, frames_per_multiframe);
        `CHK("rate", 10, bit_rate_quarters);
    endtask

    task automatic t_sync();
        sync_single_ended_pin_n <= 1'b0;
        dev(1'b1, OFF_LINK_CTRL2, 8'h30);
        `CHK("sync", 0, sync_n);
        dev(1'b0, OFF_LINK_CTRL2, 8'h00);
        `CHK("rsvd", 8'h00, s[7:0]);
        dev(1'b0, OFF_LINK_STATUS, 8'h00);
        `CHK("sync st", 8'h00, s[7:0]);
        dev(1'b1, OFF_LINK_CTRL2, 8'h40);
        `CHK("sync", 1, sync_n);
        dev(1'b0, OFF_LINK_STATUS, 8'h00);
        `CHK("sync st", 8'h20, s[7:0]);
        sync_differential_pin_n <= 1'b0;
        dev(1'b0, OFF_LINK_STATUS, 8'h00);
        `CHK("sync st", 8'h00, s[7:0]);
        `CHK("sync", 0, sync_n);
    endtask

    task automatic t_test();
        for (int i = 0; i < 12; i++) begin
            dev(1'b1, OFF_LINK_CTRL2, 8'(i));
            `CHK("pattern", i, link_test_pattern_select);
        end
        bad(OFF_LINK_CTRL2, 8'h0C);
        bad(OFF_LINK_CTRL2, 8'h0F);
        dev(1'b1, OFF_LINK_CTRL2, 8'h07);
        bad(OFF_LINK_CTRL1, 8'h9D);
        dev(1'b1, OFF_LINK_CTRL1, 8'hFF);
        `CHK("st en", 1, s[STS_LINK_EN_BIT]);
        `CHK("lrst", 0, link_reset);
        `CHK("byte", 8'hBC, test_byte);
        `CHK("is k", 1, test_byte_is_k);
        bad(OFF_LINK_CTRL1, 8'h7F);
        // Gain may change while enabled if the decimation code is kept
        dev(1'b1, OFF_DDC_CTRL, 8'h00);
        `CHK("gain on", 0, final_filter_gain_boost);
        `CHK("dec on", 4, decimation_factor);
        dev(1'b1, OFF_LINK_CTRL1, 8'hFE);
        dev(1'b1, OFF_LINK_CTRL2, 8'h0B);
        dev(1'b1, OFF_LINK_CTRL1, 8'hFF);
        `CHK("byte high", 8'hFF, test_byte);
        `CHK("not k", 0, test_byte_is_k);
        dev(1'b0, 10'h203, 8'h00);
        `CHK("unmapped", 8'h00, s[7:0]);
        wb(1'b0, 4'h8, 32'h0);
        `CHK("wb unmapped", 32'h0, s);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Whole run needs a few hundred cycles; this leaves ample margin
    initial begin
        #50us;
        error_cnt++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        sync_single_ended_pin_n = 1'b1;
        sync_differential_pin_n = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_locked();
        t_decim();
        t_link();
        t_sync();
        t_test();
        complete_run();
    end
endmodule
